// file: prcd_pkg.sv
// package: constants and carriers for the pll ratio configuration decoder
// Function
// R1 - nine plls, each with own ratio config
// R2 - four cluster plls multiply reference clock
// R3 - cores 0-3 use cluster pll one/two/three
// R4 - cores 4-7 use cluster pll three/four/one
// R5 - platform codes 5..12 give 5:1..12:1
// R6 - source sets platform range by target
// R7 - cluster codes 8-12,14,15,16 valid only
// R8 - source sets cluster range by target
// R9 - low cores select table decode
// R10 - high cores select table decode
// R11 - memory reference: system or platform clock
// R12 - memory bus clock is half data rate
// R13 - sync mode: data rate equals platform
// R14 - async: platform at least half rate
// R15 - local bus clock is platform over divider
// R16 - lane pll uses own lane reference clock
// R17 - sync select low async, high sync
// R18 - sync mode memory code 0_0001 only
// R19 - capture once at reset end, hold
// R20 - flag error on reserved codes
package prcd_pkg;
    localparam int NUM_CLUSTER = 4;
    localparam int NUM_CORE = 8;
    localparam int NUM_LANE = 3;
    localparam int NUM_PLL = NUM_CLUSTER + 2 + NUM_LANE;
    localparam int RAT_W = 5;
    localparam int SEL_W = 4;
    localparam int LANE_W = 3;
    localparam int DIV_W = 5;
    localparam logic [RAT_W-1:0] PLAT_RAT_MIN = 5'h05;
    localparam logic [RAT_W-1:0] PLAT_RAT_MAX = 5'h0C;
    localparam logic [RAT_W-1:0] CL_RAT_MIN = 5'h08;
    localparam logic [RAT_W-1:0] CL_RAT_MAX = 5'h0C;
    localparam logic [RAT_W-1:0] CL_RAT_14 = 5'h0E;
    localparam logic [RAT_W-1:0] CL_RAT_15 = 5'h0F;
    localparam logic [RAT_W-1:0] CL_RAT_16 = 5'h10;
    localparam logic [RAT_W-1:0] MEM_SYNC_RAT = 5'h01;
    localparam logic [RAT_W-1:0] MEM_SYNC_MULT = 5'h01;
    localparam logic [LANE_W-1:0] LANE_RAT_MAX = 3'h4;
    localparam logic [SEL_W-1:0] SEL_P1_D1 = 4'h0;
    localparam logic [SEL_W-1:0] SEL_P1_D2 = 4'h1;
    localparam logic [SEL_W-1:0] SEL_P2_D1 = 4'h4;
    localparam logic [SEL_W-1:0] SEL_P2_D2 = 4'h5;
    localparam logic [SEL_W-1:0] SEL_P3_D1 = 4'h8;
    localparam logic [SEL_W-1:0] SEL_P3_D2 = 4'h9;
    localparam logic [SEL_W-1:0] SEL_P4_D1 = 4'hC;
    localparam logic [SEL_W-1:0] SEL_P4_D2 = 4'hD;
    localparam logic [1:0] PLL_ONE = 2'h0;
    localparam logic [1:0] PLL_TWO = 2'h1;
    localparam logic [1:0] PLL_THREE = 2'h2;
    localparam logic [1:0] PLL_FOUR = 2'h3;
    localparam logic RST_VALID = 1'b0;

    typedef enum logic [1:0] {
        PRCD_RESET = 2'b00,
        PRCD_CAPTURE = 2'b01,
        PRCD_HOLD = 2'b11
    } prcd_state_e;

    // one core's decoded clock: which cluster pll, divide by two, legal
    typedef struct packed {
        logic [1:0] pll;
        logic div2;
        logic ok;
    } prcd_core_s;

    // memory pll setup: reference source, multiplier, legality
    typedef struct packed {
        logic ref_platform;
        logic [RAT_W-1:0] mult;
        logic ok;
    } prcd_mem_s;
endpackage

// file: prcd_core_sel.sv
// core clock select decoder for one core complex
`timescale 1ns/1ps
`default_nettype none
module prcd_core_sel
    import prcd_pkg::*;
#(
    parameter bit HIGH_GROUP = 1'b0
) (
    input wire logic [SEL_W-1:0] sel,
    output prcd_core_s dec
);
    always_comb begin
        dec = '{pll: PLL_ONE, div2: 1'b0, ok: 1'b0};
        if (!HIGH_GROUP) begin
            // low group: pll one, two or three only [R3]
            case (sel)
                SEL_P1_D1: dec = '{pll: PLL_ONE, div2: 1'b0, ok: 1'b1}; // [R9]
                SEL_P1_D2: dec = '{pll: PLL_ONE, div2: 1'b1, ok: 1'b1}; // [R9]
                SEL_P2_D1: dec = '{pll: PLL_TWO, div2: 1'b0, ok: 1'b1}; // [R9]
                SEL_P2_D2: dec = '{pll: PLL_TWO, div2: 1'b1, ok: 1'b1}; // [R9]
                SEL_P3_D1: dec = '{pll: PLL_THREE, div2: 1'b0, ok: 1'b1}; // [R9]
                default: dec = '{pll: PLL_ONE, div2: 1'b0, ok: 1'b0};
            endcase
        end else begin
            // high group: pll three, four or one only [R4]
            case (sel)
                SEL_P1_D1: dec = '{pll: PLL_ONE, div2: 1'b0, ok: 1'b1}; // [R10]
                SEL_P3_D1: dec = '{pll: PLL_THREE, div2: 1'b0, ok: 1'b1}; // [R10]
                SEL_P3_D2: dec = '{pll: PLL_THREE, div2: 1'b1, ok: 1'b1}; // [R10]
                SEL_P4_D1: dec = '{pll: PLL_FOUR, div2: 1'b0, ok: 1'b1}; // [R10]
                SEL_P4_D2: dec = '{pll: PLL_FOUR, div2: 1'b1, ok: 1'b1}; // [R10]
                default: dec = '{pll: PLL_ONE, div2: 1'b0, ok: 1'b0};
            endcase
        end
    end
endmodule
`default_nettype wire

// file: prcd_decoder.sv
// top: captures clock configuration at reset release and holds decoded settings
`timescale 1ns/1ps
`default_nettype none
module prcd_decoder
    import prcd_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_n,
    // reset configuration word fields, static while rst_n is low
    input wire logic [NUM_CLUSTER*RAT_W-1:0] cluster_ratio_field,
    input wire logic [NUM_CLUSTER*2-1:0] cluster_pll_range,
    input wire logic [RAT_W-1:0] platform_ratio_field,
    input wire logic [1:0] platform_pll_range,
    input wire logic [RAT_W-1:0] memory_ratio_field,
    input wire logic mem_sync_select,
    input wire logic [NUM_CORE*SEL_W-1:0] core_clock_select,
    input wire logic [NUM_LANE*LANE_W-1:0] lane_ratio_field,
    input wire logic [DIV_W-1:0] local_bus_divider,
    // decoded settings
    output logic [NUM_CLUSTER*RAT_W-1:0] cluster_mult_ff,
    output logic [NUM_CLUSTER*2-1:0] cluster_range_ff,
    output logic [RAT_W-1:0] platform_mult_ff,
    output logic [1:0] platform_range_ff,
    output prcd_mem_s mem_cfg_ff,
    output logic mem_bus_half_rate_ff,
    output logic [NUM_CORE*2-1:0] core_pll_ff,
    output logic [NUM_CORE-1:0] core_div2_ff,
    output logic [NUM_LANE*LANE_W-1:0] lane_ratio_ff,
    output logic [DIV_W-1:0] local_bus_div_ff,
    output logic cfg_valid_ff,
    output logic cfg_error_ff
);
    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    // fields are static straps, but still pass two flops before use
    localparam int CFG_W = NUM_CLUSTER*RAT_W + NUM_CLUSTER*2 + RAT_W + 2 + RAT_W + 1
        + NUM_CORE*SEL_W + NUM_LANE*LANE_W + DIV_W;
    logic [CFG_W-1:0] cfg_meta_ff;
    logic [CFG_W-1:0] cfg_sync_ff;
    logic [CFG_W-1:0] cfg_raw;
    assign cfg_raw = {cluster_ratio_field, cluster_pll_range, platform_ratio_field,
        platform_pll_range, memory_ratio_field, mem_sync_select, core_clock_select,
        lane_ratio_field, local_bus_divider};

    always_ff @(posedge mclk) begin
        cfg_meta_ff <= cfg_raw;
        cfg_sync_ff <= cfg_meta_ff;
    end

    logic [NUM_CLUSTER*RAT_W-1:0] s_cl_rat;
    logic [NUM_CLUSTER*2-1:0] s_cl_rng;
    logic [RAT_W-1:0] s_pl_rat;
    logic [1:0] s_pl_rng;
    logic [RAT_W-1:0] s_mem_rat;
    logic s_mem_sync;
    logic [NUM_CORE*SEL_W-1:0] s_core_sel;
    logic [NUM_LANE*LANE_W-1:0] s_lane;
    logic [DIV_W-1:0] s_lb_div;
    assign {s_cl_rat, s_cl_rng, s_pl_rat, s_pl_rng, s_mem_rat, s_mem_sync, s_core_sel,
        s_lane, s_lb_div} = cfg_sync_ff;

    // ------------------------------------------------------------
    // combinational decode
    // ------------------------------------------------------------
    logic [NUM_CLUSTER-1:0] cl_ok;
    logic [NUM_CORE-1:0] core_ok;
    logic [NUM_LANE-1:0] lane_ok;
    prcd_core_s core_dec [NUM_CORE];

    genvar gi;
    generate
        for (gi = 0; gi < NUM_CLUSTER; gi++) begin : g_cluster
            logic [RAT_W-1:0] r;
            assign r = s_cl_rat[gi*RAT_W +: RAT_W];
            // 13:1 deliberately excluded [R7]
            assign cl_ok[gi] = ((r >= CL_RAT_MIN) && (r <= CL_RAT_MAX)) || (r == CL_RAT_14)
                || (r == CL_RAT_15) || (r == CL_RAT_16);
        end
        for (gi = 0; gi < NUM_CORE; gi++) begin : g_core
            prcd_core_sel #(
                .HIGH_GROUP(gi >= (NUM_CORE/2))
            ) u_sel (
                .sel(s_core_sel[gi*SEL_W +: SEL_W]),
                .dec(core_dec[gi])
            );
            assign core_ok[gi] = core_dec[gi].ok;
        end
        for (gi = 0; gi < NUM_LANE; gi++) begin : g_lane
            assign lane_ok[gi] = s_lane[gi*LANE_W +: LANE_W] <= LANE_RAT_MAX; // [R16]
        end
    endgenerate

    logic pl_ok;
    assign pl_ok = (s_pl_rat >= PLAT_RAT_MIN) && (s_pl_rat <= PLAT_RAT_MAX); // [R5]

    // async accepts any nonzero code here; its table lies outside this block
    logic mem_ok;
    assign mem_ok = s_mem_sync ? (s_mem_rat == MEM_SYNC_RAT) : (s_mem_rat != 5'h00); // [R18]

    logic lb_ok;
    assign lb_ok = local_bus_divider_nonzero(s_lb_div);

    function automatic logic local_bus_divider_nonzero(input logic [DIV_W-1:0] d);
        return d != '0;
    endfunction

    logic any_err;
    assign any_err = !(&cl_ok) || !(&core_ok) || !(&lane_ok) || !pl_ok || !mem_ok
        || !lb_ok; // [R20]

    logic [NUM_CORE*2-1:0] core_pll_c;
    logic [NUM_CORE-1:0] core_div2_c;
    always_comb begin
        core_pll_c = '0;
        core_div2_c = '0;
        for (int i = 0; i < NUM_CORE; i++) begin
            core_pll_c[i*2 +: 2] = core_dec[i].pll;
            core_div2_c[i] = core_dec[i].div2;
        end
    end

    // ------------------------------------------------------------
    // capture sequencer
    // ------------------------------------------------------------
    // waits one cycle after release so the synchroniser holds post-reset straps
    prcd_state_e state_ff;
    prcd_state_e nxt_state;
    always_comb begin
        case (state_ff)
            PRCD_RESET: nxt_state = PRCD_CAPTURE;
            PRCD_CAPTURE: nxt_state = PRCD_HOLD;
            PRCD_HOLD: nxt_state = PRCD_HOLD;
            default: nxt_state = PRCD_RESET;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            state_ff <= PRCD_RESET;
        end else begin
            state_ff <= nxt_state;
        end
    end

    logic capture;
    assign capture = (state_ff == PRCD_CAPTURE);

    // ------------------------------------------------------------
    // held outputs
    // ------------------------------------------------------------
    // nine plls: four cluster, platform, memory, three lanes [R1]
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            cluster_mult_ff <= '0;
            cluster_range_ff <= '0;
            platform_mult_ff <= '0;
            platform_range_ff <= '0;
            lane_ratio_ff <= '0;
        end else if (capture) begin // [R19]
            // cluster ratio code is the multiplier itself [R2]
            cluster_mult_ff <= s_cl_rat;
            // range codes pass through; the source picks them by target [R8]
            cluster_range_ff <= s_cl_rng;
            platform_mult_ff <= s_pl_rat; // [R5]
            platform_range_ff <= s_pl_rng; // [R6]
            lane_ratio_ff <= s_lane; // [R16]
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            mem_cfg_ff <= '0;
            mem_bus_half_rate_ff <= 1'b0;
            local_bus_div_ff <= '0;
        end else if (capture) begin // [R19]
            // low selects async from system clock, high sync from platform [R17]
            mem_cfg_ff.ref_platform <= s_mem_sync; // [R11]
            // sync: data rate equals platform; async rests on the source's limit [R13] [R14]
            mem_cfg_ff.mult <= s_mem_sync ? MEM_SYNC_MULT : s_mem_rat;
            mem_cfg_ff.ok <= mem_ok;
            // memory bus clock always runs at half the data rate [R12]
            mem_bus_half_rate_ff <= 1'b1;
            local_bus_div_ff <= s_lb_div; // [R15]
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            core_pll_ff <= '0;
            core_div2_ff <= '0;
        end else if (capture) begin // [R19]
            core_pll_ff <= core_pll_c; // [R3] [R4]
            core_div2_ff <= core_div2_c; // [R9] [R10]
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            cfg_valid_ff <= RST_VALID;
            cfg_error_ff <= 1'b0;
        end else if (capture) begin
            cfg_valid_ff <= 1'b1;
            cfg_error_ff <= any_err; // [R20]
        end
    end
endmodule
`default_nettype wire

// file: prcd_decoder_properties.sv
// assertions on the decoded clock settings of the ratio configuration decoder
`timescale 1ns/1ps
`default_nettype none
module prcd_decoder_properties
    import prcd_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [NUM_CLUSTER*RAT_W-1:0] cluster_mult_ff,
    input wire logic [RAT_W-1:0] platform_mult_ff,
    input wire prcd_mem_s mem_cfg_ff,
    input wire logic mem_bus_half_rate_ff,
    input wire logic [NUM_CORE*2-1:0] core_pll_ff,
    input wire logic [DIV_W-1:0] local_bus_div_ff,
    input wire logic cfg_valid_ff,
    input wire logic cfg_error_ff
);
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);
    function automatic bit cl_bad(input logic [NUM_CLUSTER*RAT_W-1:0] v);
        logic [RAT_W-1:0] c;
        cl_bad = 1'b0;
        for (int i = 0; i < NUM_CLUSTER; i++) begin
            c = v[i*RAT_W+:RAT_W];
            if (!(c inside {[CL_RAT_MIN:CL_RAT_MAX], CL_RAT_14, CL_RAT_15, CL_RAT_16})) begin
                cl_bad = 1'b1;
            end
        end
    endfunction
    // low cores never reach pll four, high cores never reach pll two
    function automatic bit core_bad(input logic [NUM_CORE*2-1:0] v);
        core_bad = 1'b0;
        for (int k = 0; k < NUM_CORE; k++) begin
            if (v[k*2+:2] == (k < 4 ? PLL_FOUR : PLL_TWO)) begin
                core_bad = 1'b1;
            end
        end
    endfunction
    // ----------------------------------------
    // properties
    // ----------------------------------------
    property p_rst_clear;
        disable iff (1'b0) !rst_n |=> !cfg_valid_ff && !cfg_error_ff;
    endproperty
    a_rst_clear: assert property (p_rst_clear) else $error("reset left flags set");
    property p_capture_time;
        $rose(rst_n) |-> !cfg_valid_ff [*2] ##[1:2] cfg_valid_ff;
    endproperty
    a_capture_time: assert property (p_capture_time) else $error("capture late");
    property p_hold;
        cfg_valid_ff |=> cfg_valid_ff && $stable(platform_mult_ff) && $stable(core_pll_ff)
            && $stable(cluster_mult_ff) && $stable(cfg_error_ff);
    endproperty
    a_hold: assert property (p_hold) else $error("settings moved after capture");
    property p_plat_err;
        cfg_valid_ff && (platform_mult_ff < PLAT_RAT_MIN || platform_mult_ff > PLAT_RAT_MAX)
            |-> cfg_error_ff;
    endproperty
    a_plat_err: assert property (p_plat_err) else $error("platform code not flagged");
    property p_cl_err;
        cfg_valid_ff && cl_bad(cluster_mult_ff) |-> cfg_error_ff;
    endproperty
    a_cl_err: assert property (p_cl_err) else $error("cluster code not flagged");
    property p_core_src;
        cfg_valid_ff && !cfg_error_ff |-> !core_bad(core_pll_ff);
    endproperty
    a_core_src: assert property (p_core_src) else $error("core on wrong pll");
    property p_sync_mem;
        cfg_valid_ff && mem_cfg_ff.ref_platform |-> mem_cfg_ff.mult == MEM_SYNC_MULT;
    endproperty
    a_sync_mem: assert property (p_sync_mem) else $error("sync memory ratio wrong");
    property p_half;
        $rose(cfg_valid_ff) |-> mem_bus_half_rate_ff throughout cfg_valid_ff [*3];
    endproperty
    a_half: assert property (p_half) else $error("memory bus not half rate");
    property p_div_err;
        cfg_valid_ff && local_bus_div_ff == '0 |-> cfg_error_ff;
    endproperty
    a_div_err: assert property (p_div_err) else $error("zero divider not flagged");
endmodule
`default_nettype wire

// file: prcd_decoder_test.sv
// self-checking testbench for the ratio configuration decoder
`timescale 1ns/1ps
`default_nettype none
module prcd_decoder_test;
    import prcd_pkg::*;
    // ----------------------------------------
    // stimulus and design
    // ----------------------------------------
    typedef struct packed {
        logic [19:0] cr;
        logic [7:0] crg;
        logic [4:0] pr;
        logic [1:0] prg;
        logic [4:0] mr;
        logic ms;
        logic [31:0] cs;
        logic [8:0] lr;
        logic [4:0] ld;
    } prcd_cfg_s;
    localparam prcd_cfg_s BASE = '{cr: {5'h10, 5'h0E, 5'h0C, 5'h08}, crg: 8'hB4, pr: 5'h05,
        prg: 2'h1, mr: 5'h01, ms: 1'b1, cs: 32'hDC988541, lr: 9'h113, ld: 5'h04};
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    prcd_cfg_s drv = '0;
    prcd_cfg_s cfg;
    int err_count = 0;
    int compares = 0;
    logic [19:0] cluster_mult_ff;
    logic [7:0] cluster_range_ff;
    logic [4:0] platform_mult_ff, local_bus_div_ff;
    logic [1:0] platform_range_ff;
    prcd_mem_s mem_cfg_ff;
    logic [15:0] core_pll_ff;
    logic [7:0] core_div2_ff;
    logic [8:0] lane_ratio_ff;
    logic mem_bus_half_rate_ff, cfg_valid_ff, cfg_error_ff;
    always #20 mclk = ~mclk;
    prcd_decoder dut (.mclk, .rst_n, .cluster_ratio_field(drv.cr), .cluster_pll_range(drv.crg),
        .platform_ratio_field(drv.pr), .platform_pll_range(drv.prg), .memory_ratio_field(drv.mr),
        .mem_sync_select(drv.ms), .core_clock_select(drv.cs), .lane_ratio_field(drv.lr),
        .local_bus_divider(drv.ld), .cluster_mult_ff, .cluster_range_ff, .platform_mult_ff,
        .platform_range_ff, .mem_cfg_ff, .mem_bus_half_rate_ff, .core_pll_ff, .core_div2_ff,
        .lane_ratio_ff, .local_bus_div_ff, .cfg_valid_ff, .cfg_error_ff);
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value %s expected %0h seen %0h", name, exp, got);
        end
    endtask
    function automatic bit core_ok(input int k, input logic [3:0] c);
        return k < 4 ? c inside {4'h0, 4'h1, 4'h4, 4'h5, 4'h8}
            : c inside {4'h0, 4'h8, 4'h9, 4'hC, 4'hD};
    endfunction
    // full reset and capture of cfg, then every output against it
    task automatic run_chk(input logic e);
        logic [3:0] c;
        @(posedge mclk);
        rst_n <= 1'b0;
        drv <= cfg;
        repeat (2) @(posedge mclk);
        #1;
        chk("reset valid", 1'b0, cfg_valid_ff);
        chk("reset error", 1'b0, cfg_error_ff);
        @(posedge mclk);
        rst_n <= 1'b1;
        repeat (4) @(posedge mclk);
        #1;
        chk("valid", 1'b1, cfg_valid_ff);
        chk("error", e, cfg_error_ff);
        chk("cluster", cfg.cr, cluster_mult_ff);
        chk("cluster range", cfg.crg, cluster_range_ff);
        chk("platform", cfg.pr, platform_mult_ff);
        chk("platform range", cfg.prg, platform_range_ff);
        chk("mem ref", cfg.ms, mem_cfg_ff.ref_platform);
        chk("mem mult", cfg.ms ? 5'h01 : cfg.mr, mem_cfg_ff.mult);
        chk("mem half", 1'b1, mem_bus_half_rate_ff);
        chk("mem ok", cfg.ms ? cfg.mr == 5'h01 : cfg.mr != 5'h00, mem_cfg_ff.ok);
        chk("lane", cfg.lr, lane_ratio_ff);
        chk("divider", cfg.ld, local_bus_div_ff);
        for (int k = 0; k < 8; k++) begin
            c = cfg.cs[k*4+:4];
            chk("core pll", core_ok(k, c) ? c[3:2] : 2'h0, core_pll_ff[k*2+:2]);
            chk("core div", core_ok(k, c) & c[0], core_div2_ff[k]);
        end
    endtask
    task automatic stop_test();
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        cfg = BASE;
        run_chk(1'b0);
        @(posedge mclk);
        drv <= '0;
        repeat (3) @(posedge mclk);
        #1;
        chk("held platform", BASE.pr, platform_mult_ff);
        chk("held cluster", BASE.cr, cluster_mult_ff);
        for (int c = 0; c < 32; c++) begin
            cfg = BASE;
            cfg.pr = c[4:0];
            run_chk(c < 5 || c > 12);
            cfg = BASE;
            cfg.cr[14:10] = c[4:0];
            run_chk(!(c inside {[8:12], 14, 15, 16}));
        end
        for (int k = 1; k < 8; k += 5) begin
            for (int c = 0; c < 16; c++) begin
                cfg = BASE;
                cfg.cs[k*4+:4] = c[3:0];
                run_chk(!core_ok(k, c[3:0]));
            end
        end
        for (int c = 0; c < 64; c++) begin
            cfg = BASE;
            cfg.ms = c[5];
            cfg.mr = c[4:0];
            cfg.lr[5:3] = c[2:0];
            run_chk(c[2:0] > 4 || (c[5] ? c[4:0] != 1 : c[4:0] == 0));
        end
        for (int c = 0; c < 3; c++) begin
            cfg = BASE;
            cfg.ld = (c == 2) ? 5'h1F : c[4:0];
            run_chk(c == 0);
        end
        stop_test();
    end
    // ends a hung run well past the expected length
    initial begin
        repeat (6000) @(posedge mclk);
        err_count++;
        stop_test();
    end
endmodule
bind prcd_decoder prcd_decoder_properties u_props (.mclk, .rst_n, .cluster_mult_ff,
    .platform_mult_ff, .mem_cfg_ff, .mem_bus_half_rate_ff, .core_pll_ff, .local_bus_div_ff,
    .cfg_valid_ff, .cfg_error_ff);
`default_nettype wire
